// ==== common/display_regs.vh ====
`ifndef DISPLAY_REGS_VH
`define DISPLAY_REGS_VH

// Register addresses as carried in bits 14..8 of a serial frame.
`define ADDR_CONFIG        7'h04
`define ADDR_FONT          7'h05
`define ADDR_PLANE0_BASE   7'h20
`define ADDR_PLANE1_BASE   7'h40
`define ADDR_BOTH_BASE     7'h60
`define ADDR_DIGIT_MASK    7'h7C

// Configuration register field positions.
`define CFG_SHUTDOWN_N_BIT 0
`define CFG_RATE_BIT       2
`define CFG_ENABLE_BIT     3
`define CFG_SYNC_BIT       4
`define CFG_CLEAR_BIT      5
`define CFG_PHASE_BIT      7

// Reset and clear values.
`define CFG_RESET          8'h00
`define DIGIT_RESET        8'h20
`define DIGIT_CLEARED      8'h00
`define PTR_RESET          7'h00

// Font pointer range, held as an index above base 0x80.
`define PTR_LAST           7'h77
`define PTR_INVALID_MIN    8'hF8
`define FONT_ENTRIES       120
`define USER_SLOTS         5'h18
`define GLYPH_COLUMNS      3'h5

// Serial frame.
`define FRAME_BITS         5'h10
`define READ_FLAG_BIT      15

// Blink and scan timing in multiplex clock edges.
`define OSC_NOMINAL_HZ     4000000
`define BLINK_SLOW_PHASE_S 1
`define SCAN_PERIOD_OSC    5600
`define SCAN_SLOTS         20
`define SCAN_STEP_OSC      (`SCAN_PERIOD_OSC / `SCAN_SLOTS)

`endif

// ==== hdl/pin_sync.v ====
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter WIDTH = 4
) (
  // Clock and control
  input  wire             clk,
  input  wire             reset,
  input  wire             ce,
  // Asynchronous pins and their synchronised levels
  input  wire [WIDTH-1:0] pin_in,
  input  wire [WIDTH-1:0] rst_level,
  output reg  [WIDTH-1:0] pin_sync_out
);

  reg [WIDTH-1:0] meta_r;

  always @(posedge clk) begin
    if (reset) begin
      meta_r       <= rst_level;
      pin_sync_out <= rst_level;
    end else if (ce) begin
      meta_r       <= pin_in;
      pin_sync_out <= meta_r;
    end
  end

endmodule

`default_nettype wire

// ==== hdl/led_matrix_blink_font_control.v ====
`include "display_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module led_matrix_blink_font_control #(
  parameter BLINK_SLOW_EDGES = `BLINK_SLOW_PHASE_S * `OSC_NOMINAL_HZ
) (
  // Clock, reset and enable
  input  wire       clk,
  input  wire       reset,
  input  wire       ce,
  // Serial register port
  input  wire       cs_n,
  input  wire       sclk,
  input  wire       din,
  output wire       dout,
  // Multiplex clock
  input  wire       multiplex_clock_pin,
  // Blink phase and mode
  output reg        blink_r,
  output wire       shutdown_n,
  // Scan position and glyph lookup
  output reg  [1:0] scan_digit_r,
  output reg  [2:0] scan_col_r,
  output reg  [6:0] rom_code_p0_r,
  output reg  [6:0] rom_code_p1_r,
  input  wire [6:0] rom_dots_p0,
  input  wire [6:0] rom_dots_p1,
  output reg  [6:0] col_dots_r
);

  localparam [31:0] SLOW_FULL  = BLINK_SLOW_EDGES;
  localparam [31:0] STEP_FULL  = `SCAN_STEP_OSC;
  localparam [21:0] SLOW_EDGES = SLOW_FULL[21:0];
  localparam [21:0] FAST_EDGES = SLOW_FULL[22:1];
  localparam [8:0]  STEP_EDGES = STEP_FULL[8:0];

  // Pointer after one font data access, wrapping at the last location.
  function [6:0] ptr_advance;
    input [6:0] p;
    begin
      if (p == `PTR_LAST)
        ptr_advance = `PTR_RESET;
      else
        ptr_advance = p + 7'h01;
    end
  endfunction

  // Font entry holding a column of a user glyph, five entries per slot.
  function [6:0] glyph_index;
    input [4:0] slot;
    input [2:0] col;
    reg   [9:0] prod;
    begin
      prod        = {5'h00, slot} * 10'd5 + {7'h00, col};
      glyph_index = prod[6:0];
    end
  endfunction

  // Codes below 0x18 are user slots; the MSB of the digit is polarity.
  function is_user;
    input [7:0] code;
    begin
      is_user = (code[6:5] == 2'b00) && (code[4:0] < `USER_SLOTS);
    end
  endfunction

  // Dots of one plane, taken from user storage or the glyph ROM, then polarity applied.
  function [6:0] plane_dots;
    input [7:0] chr;
    input [6:0] user;
    input [6:0] rom;
    begin
      if (is_user(chr))
        plane_dots = user ^ {7{chr[7]}};
      else
        plane_dots = rom ^ {7{chr[7]}};
    end
  endfunction

  wire [3:0] sync_lvl;
  wire       cs_s   = sync_lvl[0];
  wire       sclk_s = sync_lvl[1];
  wire       din_s  = sync_lvl[2];
  wire       osc_s  = sync_lvl[3];

  pin_sync #(.WIDTH(4)) u_sync (
    .clk          (clk),
    .reset        (reset),
    .ce           (ce),
    .pin_in       ({multiplex_clock_pin, din, sclk, cs_n}),
    .rst_level    (4'h3),
    .pin_sync_out (sync_lvl)
  );

  reg  [2:0]  cfg_r;
  reg  [7:0]  plane0_r [0:3];
  reg  [7:0]  plane1_r [0:3];
  reg  [6:0]  font_ram [0:`FONT_ENTRIES-1];
  reg  [6:0]  ptr_r;
  reg         cs_q_r;
  reg         sclk_q_r;
  reg         osc_q_r;
  reg  [4:0]  bit_cnt_r;
  reg  [15:0] in_sh_r;
  reg  [15:0] out_sh_r;
  reg  [21:0] blink_cnt_r;
  reg  [8:0]  step_cnt_r;
  reg         resync_r;
  integer     i;

  wire        cs_rise   = cs_s & ~cs_q_r;
  wire        cs_fall   = ~cs_s & cs_q_r;
  wire        sclk_rise = sclk_s & ~sclk_q_r & ~cs_s;
  wire        sclk_fall = ~sclk_s & sclk_q_r & ~cs_s;
  wire        osc_rise  = osc_s & ~osc_q_r;
  wire        frame_ok  = cs_rise && (bit_cnt_r == `FRAME_BITS);
  wire        is_read   = in_sh_r[`READ_FLAG_BIT];
  wire [6:0]  addr      = in_sh_r[14:8];
  wire [7:0]  wdata     = in_sh_r[7:0];
  wire        at_cfg    = (addr == `ADDR_CONFIG);
  wire        at_font   = (addr == `ADDR_FONT);
  wire        at_p0     = ((addr & `ADDR_DIGIT_MASK) == `ADDR_PLANE0_BASE);
  wire        at_p1     = ((addr & `ADDR_DIGIT_MASK) == `ADDR_PLANE1_BASE);
  wire        at_both   = ((addr & `ADDR_DIGIT_MASK) == `ADDR_BOTH_BASE);
  wire [1:0]  dsel      = addr[1:0];
  wire [21:0] phase_len = cfg_r[1] ? FAST_EDGES : SLOW_EDGES;

  assign dout       = out_sh_r[15];
  assign shutdown_n = cfg_r[0];

  reg [7:0] rd_data;

  always @* begin
    rd_data = 8'h00;
    if (at_cfg)
      rd_data = {blink_r, 3'b000, cfg_r[2], cfg_r[1], 1'b0, cfg_r[0]};
    else if (at_font)
      rd_data = {1'b0, font_ram[ptr_r]};
    else if (at_p0)
      rd_data = plane0_r[dsel];
    else if (at_p1)
      rd_data = plane1_r[dsel];
  end

  // Serial framing on sclk and chip-select edges; register effects all applied at chip-select rise.
  always @(posedge clk) begin
    if (reset) begin
      cs_q_r    <= 1'b1;
      sclk_q_r  <= 1'b1;
      osc_q_r   <= 1'b0;
      bit_cnt_r <= 5'h00;
      in_sh_r   <= 16'h0000;
      out_sh_r  <= 16'h0000;
      cfg_r     <= 3'h0;
      ptr_r     <= `PTR_RESET;
      resync_r  <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        plane0_r[i] <= `DIGIT_RESET;
        plane1_r[i] <= `DIGIT_RESET;
      end
    end else if (ce) begin
      cs_q_r   <= cs_s;
      sclk_q_r <= sclk_s;
      osc_q_r  <= osc_s;
      resync_r <= 1'b0;
      if (cs_fall)
        bit_cnt_r <= 5'h00;
      if (sclk_rise) begin
        in_sh_r <= {in_sh_r[14:0], din_s};
        if (bit_cnt_r <= `FRAME_BITS)
          bit_cnt_r <= bit_cnt_r + 5'h01;
      end
      if (sclk_fall)
        out_sh_r <= {out_sh_r[14:0], 1'b0};
      // A short or long frame is dropped, as a partial shift would corrupt data.
      if (frame_ok && is_read) begin
        out_sh_r <= {in_sh_r[15:8], rd_data};
        if (at_font)
          ptr_r <= ptr_advance(ptr_r);
      end
      if (frame_ok && !is_read) begin
        if (at_cfg) begin
          cfg_r <= {wdata[`CFG_ENABLE_BIT], wdata[`CFG_RATE_BIT],
                    wdata[`CFG_SHUTDOWN_N_BIT]};
          resync_r <= wdata[`CFG_SYNC_BIT];
          if (wdata[`CFG_CLEAR_BIT]) begin
            for (i = 0; i < 4; i = i + 1) begin
              plane0_r[i] <= `DIGIT_CLEARED;
              plane1_r[i] <= `DIGIT_CLEARED;
            end
          end
        end
        if (at_font) begin
          if (wdata[7]) begin
            if (wdata >= `PTR_INVALID_MIN)
              ptr_r <= `PTR_RESET;
            else
              ptr_r <= wdata[6:0];
          end else begin
            ptr_r <= ptr_advance(ptr_r);
          end
        end
        if (at_p0 || at_both)
          plane0_r[dsel] <= wdata;
        if (at_p1 || at_both)
          plane1_r[dsel] <= wdata;
      end
    end
  end

  // Font storage has no reset; its 120 entries hold the five columns of each user slot.
  always @(posedge clk) begin
    if (ce && frame_ok && !is_read && at_font && !wdata[7])
      font_ram[ptr_r] <= wdata[6:0];
  end

  // Blink phase and scan sequencing, stepped by multiplex clock edges.
  always @(posedge clk) begin
    if (reset) begin
      blink_cnt_r  <= 22'h000000;
      blink_r      <= 1'b1;
      step_cnt_r   <= 9'h000;
      scan_col_r   <= 3'h0;
      scan_digit_r <= 2'h0;
    end else if (ce) begin
      if (resync_r) begin
        blink_cnt_r  <= 22'h000000;
        blink_r      <= 1'b1;
        step_cnt_r   <= 9'h000;
        scan_col_r   <= 3'h0;
        scan_digit_r <= 2'h0;
      end else if (osc_rise) begin
        if (blink_cnt_r >= phase_len - 22'h000001) begin
          blink_cnt_r <= 22'h000000;
          blink_r     <= ~blink_r;
        end else begin
          blink_cnt_r <= blink_cnt_r + 22'h000001;
        end
        if (step_cnt_r == STEP_EDGES - 9'h001) begin
          step_cnt_r <= 9'h000;
          if (scan_col_r == `GLYPH_COLUMNS - 3'h1) begin
            scan_col_r   <= 3'h0;
            scan_digit_r <= scan_digit_r + 2'h1;
          end else begin
            scan_col_r <= scan_col_r + 3'h1;
          end
        end else begin
          step_cnt_r <= step_cnt_r + 9'h001;
        end
      end
    end
  end

  wire [7:0] chr0   = plane0_r[scan_digit_r];
  wire [7:0] chr1   = plane1_r[scan_digit_r];
  wire [6:0] user0  = font_ram[glyph_index(chr0[4:0], scan_col_r)];
  wire [6:0] user1  = font_ram[glyph_index(chr1[4:0], scan_col_r)];
  wire [6:0] dots0  = plane_dots(chr0, user0, rom_dots_p0);
  wire [6:0] dots1  = plane_dots(chr1, user1, rom_dots_p1);

  // Glyph code and dot column; the ROM answers the code registered a cycle earlier.
  always @(posedge clk) begin
    if (reset) begin
      rom_code_p0_r <= 7'h00;
      rom_code_p1_r <= 7'h00;
      col_dots_r    <= 7'h00;
    end else if (ce) begin
      rom_code_p0_r <= chr0[6:0];
      rom_code_p1_r <= chr1[6:0];
      if (cfg_r[2])
        col_dots_r <= blink_r ? dots0 : dots1;
      else
        col_dots_r <= dots0;
    end
  end

endmodule

`default_nettype wire

// ==== dv/serial_host.sv ====
`timescale 1ns/1ps
`default_nettype none

module serial_host (
  // Pacing clock
  input  wire logic clk,
  // Serial pins
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  input  wire logic dout
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end

  // Four clocks between edges keeps clear of the three-clock sampling delay.
  task automatic gap;
    repeat (4) @(negedge clk);
  endtask

  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    int i;
    cs_n = 1'b0;
    for (i = 15; i >= 0; i--) begin
      din = w[i];
      gap();
      r[i] = dout;
      sclk = 1'b1;
      gap();
      sclk = 1'b0;
    end
    gap();
    cs_n = 1'b1;
    din  = ~din;
    repeat (3) gap();
  endtask
endmodule

`default_nettype wire

// ==== dv/blink_font_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none

module blink_font_monitor #(
  parameter BLINK_SLOW_EDGES = 20
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset,
  // Serial pins
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic       dout,
  // Display state
  input wire logic       blink_r,
  input wire logic       shutdown_n,
  input wire logic [1:0] scan_digit_r,
  input wire logic [2:0] scan_col_r
);
  a_reset_state: assert property (@(posedge clk) reset |=> blink_r && !shutdown_n
    && scan_digit_r == 2'h0 && scan_col_r == 3'h0) else $error("reset state wrong");
  a_col_range: assert property (@(posedge clk) disable iff (reset)
    scan_col_r <= 3'h4) else $error("column out of range");
  a_col_step: assert property (@(posedge clk) disable iff (reset)
    $changed(scan_col_r) |-> scan_col_r == 3'h0 || scan_col_r == $past(scan_col_r) + 3'h1)
    else $error("column step wrong");
  a_digit_step: assert property (@(posedge clk) disable iff (reset)
    $changed(scan_digit_r) |-> scan_col_r == 3'h0
    && (scan_digit_r == 2'h0 || scan_digit_r == $past(scan_digit_r) + 2'h1))
    else $error("digit step wrong");
  a_blink_high_hold: assert property (@(posedge clk) disable iff (reset)
    $rose(blink_r) |=> blink_r [*8]) else $error("first phase too short");
  a_blink_low_hold: assert property (@(posedge clk) disable iff (reset)
    $fell(blink_r) |=> !blink_r [*8]) else $error("second phase too short");
  a_dout_sclk_low: assert property (@(posedge clk) disable iff (reset)
    $changed(dout) |-> !sclk) else $error("dout moved while sclk high");
  a_config_at_cs: assert property (@(posedge clk) disable iff (reset)
    $changed(shutdown_n) |-> cs_n) else $error("config changed inside frame");
endmodule

bind led_matrix_blink_font_control blink_font_monitor #(
  .BLINK_SLOW_EDGES(BLINK_SLOW_EDGES)
) u_mon (.clk(clk), .reset(reset), .cs_n(cs_n), .sclk(sclk), .dout(dout), .blink_r(blink_r),
  .shutdown_n(shutdown_n), .scan_digit_r(scan_digit_r), .scan_col_r(scan_col_r));

`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        clk, reset, cs_n, sclk, din, dout, osc, blink_r, shutdown_n;
  logic [1:0]  scan_digit_r;
  logic [2:0]  scan_col_r;
  logic [6:0]  code0, code1, dots0, dots1, col_dots_r;
  logic [15:0] rd;
  int          errors, compares, n, i;

  led_matrix_blink_font_control #(.BLINK_SLOW_EDGES(20)) u_dut (.clk(clk), .reset(reset),
    .ce(1'b1), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .multiplex_clock_pin(osc),
    .blink_r(blink_r), .shutdown_n(shutdown_n), .scan_digit_r(scan_digit_r),
    .scan_col_r(scan_col_r), .rom_code_p0_r(code0), .rom_code_p1_r(code1),
    .rom_dots_p0(dots0), .rom_dots_p1(dots1), .col_dots_r(col_dots_r));
  serial_host u_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));

  initial begin clk = 1'b0; forever #12.5 clk = ~clk; end
  initial begin osc = 1'b0; forever #100 osc = ~osc; end
  // Stand-in glyph store: a fixed scramble of the code, so each code has known dots.
  always @(negedge clk) begin
    dots0 <= code0 ^ 7'h2A;
    dots1 <= code1 ^ 7'h2A;
  end

  task automatic final_report;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] want);
    compares++;
    if (got !== want) begin
      errors++;
      $display("BAD at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer({1'b0, a, d}, rd);
  endtask
  // The answer to a read comes out during the following frame.
  task automatic rdchk(input logic [6:0] a, input logic [7:0] want);
    u_host.xfer({1'b1, a, 8'h00}, rd);
    u_host.xfer(16'h0000, rd);
    check({8'h00, rd[7:0]}, {8'h00, want});
  endtask
  task automatic wait_blink(input logic lvl);
    n = 0;
    while (blink_r !== lvl) begin
      @(negedge clk);
      n++;
      if (n > 2000) begin errors++; final_report(); end
    end
  endtask
  // One phase is 20 or 10 multiplex clock edges of eight clocks each, give or take sync jitter.
  task automatic measure(input int want);
    wait_blink(1'b1);
    wait_blink(1'b0);
    wait_blink(1'b1);
    check(16'((n >= want - 12 && n <= want + 12) ? want : n), 16'(want));
  endtask

  initial begin
    reset = 1'b1;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    wr(7'h05, 8'hF6);
    wr(7'h05, 8'h11);
    wr(7'h05, 8'h7F);
    wr(7'h05, 8'h33);
    wr(7'h05, 8'hF6);
    rdchk(7'h05, 8'h11);
    rdchk(7'h05, 8'h7F);
    rdchk(7'h05, 8'h33);
    wr(7'h05, 8'hFA);
    rdchk(7'h05, 8'h33);
    wr(7'h05, 8'h99);
    for (i = 0; i < 5; i++) wr(7'h05, 8'h10 + 8'(i));
    for (i = 0; i < 4; i++) wr(7'h20 + 7'(i), 8'hC1);
    for (i = 0; i < 4; i++) wr(7'h40 + 7'(i), 8'h05);
    wr(7'h04, 8'h01);
    repeat (6) @(negedge clk);
    check({9'h000, code0}, 16'h0041);
    check({9'h000, col_dots_r}, 16'h0014);
    check({8'h00, shutdown_n, code1}, 16'h0085);
    wr(7'h04, 8'h09);
    wait_blink(1'b0);
    repeat (6) @(negedge clk);
    check({9'h000, col_dots_r}, 16'h0010 + 16'(scan_col_r));
    wait_blink(1'b1);
    repeat (6) @(negedge clk);
    check({9'h000, col_dots_r}, 16'h0014);
    wait_blink(1'b0);
    wr(7'h04, 8'h19);
    check({13'h0000, blink_r, scan_col_r != 3'h0, scan_digit_r != 2'h0}, 16'h0004);
    rdchk(7'h04, 8'h89);
    wait_blink(1'b1);
    wait_blink(1'b0);
    wr(7'h04, 8'h09);
    check({15'h0000, blink_r}, 16'h0000);
    wait_blink(1'b1);
    wait_blink(1'b0);
    rdchk(7'h04, 8'h09);
    measure(160);
    wr(7'h04, 8'h0D);
    measure(80);
    wr(7'h20, 8'h41);
    wr(7'h40, 8'h42);
    wr(7'h04, 8'h29);
    rdchk(7'h20, 8'h00);
    rdchk(7'h41, 8'h00);
    rdchk(7'h40, 8'h00);
    wr(7'h04, 8'h01);
    for (i = 0; i < 4; i++) wr(7'h60 + 7'(i), 8'h18);
    check({9'h000, col_dots_r}, 16'h0032);
    check({1'b0, code0, 1'b0, code1}, 16'h1818);
    rdchk(7'h43, 8'h18);
    rdchk(7'h60, 8'h00);
    final_report();
  end
endmodule

`default_nettype wire
